// *** common/xbi_consts.svh ***
/*
  Constants for the external bus interface of the signal-processor device.
  Assumes inclusion by bare name from the design file; definitions only.
*/
//
// Behaviour
// RQ1: Space select low only during its access.
// RQ2: Memory strobe low only for memory access.
// RQ3: I/O strobe low only for I/O access.
// RQ4: Direction high, low only when writing.
// RQ5: Ready low: wait a cycle, resample.
// RQ6: Ready sampled only after two-plus software waits.
// RQ7: Wait-complete low first wait, high last.
// RQ8: Wait-complete looped to ready adds one wait.
// RQ9: Hold request acknowledged by releasing bus lines.
// RQ10: Hold acknowledge only while lines released.
// RQ11: Hold mode floats selects, strobes, direction.
// RQ12: Output disable floats every bus output.
// RQ13: Fetch indicator low for instruction addresses.
// RQ14: Clock output toggles once per machine cycle.
// RQ15: Data bus floats unless writing, reset, hold.
// RQ16: Bus holder keeps last driven data level; data_o takes each access's write data, reads included.
// RQ17: Software wait count from configuration input.
`ifndef XBI_CONSTS_SVH
`define XBI_CONSTS_SVH
`define XBI_SPACE_DATA 2'h0
`define XBI_SPACE_PROG 2'h1
`define XBI_SPACE_IO   2'h2
`define XBI_MIN_READY_WAITS 3'h2
`define XBI_ONE_WAIT 3'h1
`define XBI_ZERO_WAIT 3'h0
`endif

// *** common/xbi_pkg.sv ***
/*
  Types for the external bus interface.
  Assumes the constants header is compiled alongside.
*/
package xbi_pkg;
  typedef enum logic [2:0] {
    XBI_IDLE,
    XBI_WAIT,
    XBI_READY,
    XBI_HOLD
  } xbi_state_t;
endpackage

// *** hdl/xbi_bus.sv ***
/*
  External memory and I/O bus interface: selects, strobes, direction, waits,
  hold handshake, fetch indicator, machine-cycle clock and data bus drive.
  Assumes request inputs are synchronous to clk and held until req_done.
*/
`timescale 1ns/100ps
`include "xbi_consts.svh"
`default_nettype none
module xbi_bus #(
  parameter int DW = 16,
  parameter int AW = 16
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rstn,
  // Core request side
  input  wire logic          req_valid,
  input  wire logic [1:0]    req_space,
  input  wire logic          req_write,
  input  wire logic          req_fetch,
  input  wire logic [AW-1:0] req_addr,
  input  wire logic [DW-1:0] req_wdata,
  input  wire logic [2:0]    sw_wait_count,
  output logic               req_done,
  output logic [DW-1:0]      req_rdata,
  // External bus
  input  wire logic          ready,
  input  wire logic          hold_req_n,
  input  wire logic          output_disable_n,
  input  wire logic          device_reset_n,
  output logic [AW-1:0]      addr_o,
  output logic               addr_oe_n,
  input  wire logic [DW-1:0] data_i,
  output logic [DW-1:0]      data_o,
  output logic               data_oe_n,
  output logic               data_space_select_n,
  output logic               program_space_select_n,
  output logic               io_space_select_n,
  output logic               memory_strobe_n,
  output logic               io_strobe_n,
  output logic               rw_dir,
  output logic               ctl_oe_n,
  output logic               bus_grant_ack_n,
  output logic               wait_complete_n,
  output logic               instr_fetch_n,
  output logic               machine_cycle_clock_out,
  output logic               misc_oe_n
);

  logic rst_sync1_ff;
  logic rst_sync2_ff;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync1_ff <= 1'b0;
      rst_sync2_ff <= 1'b0;
    end else begin
      rst_sync1_ff <= 1'b1;
      rst_sync2_ff <= rst_sync1_ff;
    end
  end

  // Access sequencing state
  xbi_pkg::xbi_state_t state_ff;
  xbi_pkg::xbi_state_t nxt_state;
  logic [2:0]          wcnt_ff;
  logic [2:0]          nxt_wcnt;
  logic [1:0]          space_ff;
  logic [1:0]          nxt_space;
  logic                write_ff;
  logic                nxt_write;
  logic                fetch_ff;
  logic                nxt_fetch;
  logic [AW-1:0]       addr_ff;
  logic [AW-1:0]       nxt_addr;
  logic [DW-1:0]       wdata_ff;
  logic [DW-1:0]       nxt_wdata;
  logic [DW-1:0]       rdata_ff;
  logic [DW-1:0]       nxt_rdata;
  logic                done_ff;
  logic                nxt_done;
  logic                finish;

  // Registered pin drivers
  logic                msc_ff;
  logic                nxt_msc;
  logic                machine_cycle_clock_out_ff;
  logic                nxt_machine_cycle_clock_out;
  logic                ds_ff;
  logic                ps_ff;
  logic                is_ff;
  logic                ms_ff;
  logic                ios_ff;
  logic                rw_ff;
  logic                dataoe_ff;
  logic                nxt_ds;
  logic                nxt_ps;
  logic                nxt_is;
  logic                nxt_ms;
  logic                nxt_ios;
  logic                nxt_rw;
  logic                nxt_dataoe;
  logic                ctloe_ff;
  logic                nxt_ctloe;
  logic                bus_grant_ack_n_ff;
  logic                nxt_bus_grant_ack_n;
  logic                miscoe_ff;
  logic                nxt_miscoe;
  logic                iaq_ff;
  logic                nxt_iaq;
  logic                addroe_ff;
  logic                nxt_addroe;

  // Ready sample stages
  logic                rdy1_ff;
  logic                nxt_rdy1;
  logic                rdy2_ff;
  logic                nxt_rdy2;

  always_comb begin
    nxt_state  = state_ff;
    nxt_wcnt   = wcnt_ff;
    nxt_space  = space_ff;
    nxt_write  = write_ff;
    nxt_fetch  = fetch_ff;
    nxt_addr   = addr_ff;
    nxt_wdata  = wdata_ff;
    nxt_rdata  = rdata_ff;
    nxt_done   = 1'b0;
    nxt_msc    = 1'b1;
    nxt_machine_cycle_clock_out = ~machine_cycle_clock_out_ff; // RQ14
    finish     = 1'b0;
    case (state_ff)
      xbi_pkg::XBI_IDLE: begin
        if (!hold_req_n) begin
          nxt_state = xbi_pkg::XBI_HOLD; // RQ9
        end else if (req_valid && !done_ff) begin
          nxt_space = req_space;
          nxt_write = req_write;
          nxt_fetch = req_fetch;
          nxt_addr  = req_addr;
          nxt_wdata = req_wdata;
          nxt_wcnt  = sw_wait_count; // RQ17
          if (sw_wait_count == `XBI_ZERO_WAIT) begin
            nxt_state = xbi_pkg::XBI_READY;
          end else begin
            nxt_state = xbi_pkg::XBI_WAIT;
            // Active from the first software wait state
            nxt_msc = !(sw_wait_count >= `XBI_MIN_READY_WAITS); // RQ7
          end
        end
      end
      xbi_pkg::XBI_WAIT: begin
        nxt_wcnt = wcnt_ff - `XBI_ONE_WAIT;
        // Stays low until the start of the last wait state
        nxt_msc  = !(wcnt_ff > `XBI_MIN_READY_WAITS); // RQ7
        if (wcnt_ff == `XBI_ONE_WAIT) begin
          nxt_state = xbi_pkg::XBI_READY;
        end
      end
      xbi_pkg::XBI_READY: begin
        // Ready only considered with two or more programmed waits
        // Two-stage sample, so a looped wait-complete adds one wait
        if (sw_wait_count < `XBI_MIN_READY_WAITS || rdy2_ff) begin // RQ5 RQ6 RQ8
          finish = 1'b1;
        end
        if (finish) begin
          nxt_done  = 1'b1;
          nxt_state = xbi_pkg::XBI_IDLE;
          if (!write_ff) begin
            nxt_rdata = data_i;
          end
        end
      end
      xbi_pkg::XBI_HOLD: begin
        if (hold_req_n) begin
          nxt_state = xbi_pkg::XBI_IDLE;
        end
      end
      default: begin
        nxt_state = xbi_pkg::XBI_IDLE;
      end
    endcase
  end

  always_comb begin
    nxt_ps     = !(nxt_state inside {xbi_pkg::XBI_WAIT, xbi_pkg::XBI_READY} &&
                   nxt_space == `XBI_SPACE_PROG); // RQ1
    nxt_ds     = !(nxt_state inside {xbi_pkg::XBI_WAIT, xbi_pkg::XBI_READY} &&
                   nxt_space == `XBI_SPACE_DATA); // RQ1
    nxt_is     = !(nxt_state inside {xbi_pkg::XBI_WAIT, xbi_pkg::XBI_READY} &&
                   nxt_space == `XBI_SPACE_IO); // RQ1
    nxt_ms     = nxt_ds & nxt_ps; // RQ2
    nxt_ios    = nxt_is; // RQ3
    nxt_rw     = !(nxt_state inside {xbi_pkg::XBI_WAIT, xbi_pkg::XBI_READY} && nxt_write); // RQ4
    nxt_iaq    = !(nxt_state inside {xbi_pkg::XBI_WAIT, xbi_pkg::XBI_READY} && nxt_fetch); // RQ13
    nxt_bus_grant_ack_n  = !((nxt_state == xbi_pkg::XBI_HOLD) && output_disable_n); // RQ10 RQ12
    nxt_ctloe  = (nxt_state == xbi_pkg::XBI_HOLD) || !output_disable_n; // RQ11 RQ12
    nxt_addroe = nxt_ctloe; // RQ9
    nxt_miscoe = !output_disable_n; // RQ12
    // Data driven only on a write, never in reset, hold or disable
    nxt_dataoe = !(nxt_state inside {xbi_pkg::XBI_WAIT, xbi_pkg::XBI_READY} && nxt_write &&
                   device_reset_n && output_disable_n && hold_req_n); // RQ15
  end

  // Ready pin sampled through two stages
  always_comb begin
    nxt_rdy1 = ready;
    nxt_rdy2 = rdy1_ff; // RQ8
  end

  always_ff @(posedge clk or negedge rst_sync2_ff) begin
    if (!rst_sync2_ff) begin
      rdy1_ff <= 1'b1;
      rdy2_ff <= 1'b1;
    end else begin
      rdy1_ff <= nxt_rdy1;
      rdy2_ff <= nxt_rdy2;
    end
  end

  // Sequencing registers
  always_ff @(posedge clk or negedge rst_sync2_ff) begin
    if (!rst_sync2_ff) begin
      state_ff  <= xbi_pkg::XBI_IDLE;
      wcnt_ff   <= `XBI_ZERO_WAIT;
      space_ff  <= `XBI_SPACE_DATA;
      write_ff  <= 1'b0;
      fetch_ff  <= 1'b0;
      addr_ff   <= '0;
      wdata_ff  <= '0;
      rdata_ff  <= '0;
      done_ff   <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      wcnt_ff   <= nxt_wcnt;
      space_ff  <= nxt_space;
      write_ff  <= nxt_write;
      fetch_ff  <= nxt_fetch;
      addr_ff   <= nxt_addr;
      wdata_ff  <= nxt_wdata; // RQ16
      rdata_ff  <= nxt_rdata;
      done_ff   <= nxt_done;
    end
  end

  // Pin driver registers, idle levels in reset
  always_ff @(posedge clk or negedge rst_sync2_ff) begin
    if (!rst_sync2_ff) begin
      msc_ff    <= 1'b1;
      machine_cycle_clock_out_ff <= 1'b0;
      ds_ff     <= 1'b1;
      ps_ff     <= 1'b1;
      is_ff     <= 1'b1;
      ms_ff     <= 1'b1;
      ios_ff    <= 1'b1;
      rw_ff     <= 1'b1;
      iaq_ff    <= 1'b1;
      bus_grant_ack_n_ff  <= 1'b1;
      ctloe_ff  <= 1'b0;
      addroe_ff <= 1'b0;
      miscoe_ff <= 1'b0;
      dataoe_ff <= 1'b1;
    end else begin
      msc_ff    <= nxt_msc;
      machine_cycle_clock_out_ff <= nxt_machine_cycle_clock_out;
      ds_ff     <= nxt_ds;
      ps_ff     <= nxt_ps;
      is_ff     <= nxt_is;
      ms_ff     <= nxt_ms;
      ios_ff    <= nxt_ios;
      rw_ff     <= nxt_rw;
      iaq_ff    <= nxt_iaq;
      bus_grant_ack_n_ff  <= nxt_bus_grant_ack_n;
      ctloe_ff  <= nxt_ctloe;
      addroe_ff <= nxt_addroe;
      miscoe_ff <= nxt_miscoe;
      dataoe_ff <= nxt_dataoe;
    end
  end

  // Data output keeps the write data of the last access, read or write, acting as the bus holder
  assign addr_o                  = addr_ff;
  assign addr_oe_n               = addroe_ff;
  assign data_o                  = wdata_ff; // RQ16
  assign data_oe_n               = dataoe_ff;
  assign data_space_select_n     = ds_ff;
  assign program_space_select_n  = ps_ff;
  assign io_space_select_n       = is_ff;
  assign memory_strobe_n         = ms_ff;
  assign io_strobe_n             = ios_ff;
  assign rw_dir                  = rw_ff;
  assign ctl_oe_n                = ctloe_ff;
  assign bus_grant_ack_n         = bus_grant_ack_n_ff;
  assign wait_complete_n         = msc_ff;
  assign instr_fetch_n           = iaq_ff;
  assign machine_cycle_clock_out = machine_cycle_clock_out_ff;
  assign misc_oe_n               = miscoe_ff;
  assign req_done                = done_ff;
  assign req_rdata               = rdata_ff;

endmodule
`default_nettype wire

// *** test/xbi_bus_assertions.sv ***
/*
  Pin-level checker for the external bus interface.
  Assumes it is bound to xbi_bus and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none
module xbi_bus_assertions (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rstn,
  // Watched ports
  input wire logic       req_write,
  input wire logic       req_fetch,
  input wire logic [2:0] sw_wait_count,
  input wire logic       hold_req_n,
  input wire logic       output_disable_n,
  input wire logic       data_space_select_n,
  input wire logic       program_space_select_n,
  input wire logic       io_space_select_n,
  input wire logic       memory_strobe_n,
  input wire logic       io_strobe_n,
  input wire logic       rw_dir,
  input wire logic       ctl_oe_n,
  input wire logic       addr_oe_n,
  input wire logic       data_oe_n,
  input wire logic       misc_oe_n,
  input wire logic       bus_grant_ack_n,
  input wire logic       wait_complete_n,
  input wire logic       instr_fetch_n,
  input wire logic       machine_cycle_clock_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  wire acc_on = !memory_strobe_n || !io_strobe_n;
  sel_one_hot_a: assert property ($onehot0(~{data_space_select_n, program_space_select_n, io_space_select_n}))
    else $error("two space selects low");
  mem_strobe_a: assert property (!memory_strobe_n |-> io_strobe_n && io_space_select_n)
    else $error("memory strobe on I/O access");
  io_strobe_a: assert property (!io_strobe_n |-> !io_space_select_n && memory_strobe_n)
    else $error("I/O strobe without I/O select");
  write_dir_a: assert property (!ctl_oe_n && !rw_dir |-> acc_on && req_write)
    else $error("direction low outside a write");
  wait_start_a: assert property ($fell(wait_complete_n) |-> sw_wait_count >= 3'h2 && acc_on)
    else $error("wait complete active with few waits");
  fetch_mark_a: assert property (!instr_fetch_n && !misc_oe_n |-> req_fetch)
    else $error("fetch marked on data access");
  hold_float_a: assert property (!bus_grant_ack_n |-> ctl_oe_n && addr_oe_n && data_oe_n)
    else $error("hold acknowledged with lines driven");
  hold_cause_a: assert property (!bus_grant_ack_n |-> !hold_req_n || $past(!hold_req_n))
    else $error("hold acknowledged without request");
  off_float_a: assert property (!output_disable_n [*2] |-> ctl_oe_n && misc_oe_n && addr_oe_n && data_oe_n)
    else $error("outputs driven while disabled");
  clk_toggle_a: assert property (acc_on |=> machine_cycle_clock_out != $past(machine_cycle_clock_out))
    else $error("machine clock did not toggle");
  cover property (!wait_complete_n);
  cover property (!bus_grant_ack_n);
  cover property (!rw_dir && !io_strobe_n);
endmodule
bind xbi_bus xbi_bus_assertions u_xbi_bus_assertions (.*);
`default_nettype wire

// *** test/xbi_bus_test.sv ***
/*
  Self-checking bench for the external bus interface.
  Assumes the checker is bound and the device model answers on the bus.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; $display("[FAIL] %0t mismatch", $time); end end
module xbi_bus_test;
  logic clk = 1'b0, rstn = 1'b0, req_valid = 1'b0, req_write = 1'b0, req_fetch = 1'b0, loop = 1'b0;
  logic hold_req_n = 1'b1, output_disable_n = 1'b1, device_reset_n = 1'b1;
  logic [1:0] req_space = 2'h0;
  logic [2:0] sw_wait_count = 3'h0, slow = 3'h0;
  logic [15:0] req_addr = 16'h0000, req_wdata = 16'h0000, rnd = 16'h0029;
  logic [15:0] req_rdata, addr_o, data_i, data_o, exp_mem [0:7];
  logic req_done, addr_oe_n, data_oe_n, data_space_select_n, program_space_select_n, io_space_select_n;
  logic memory_strobe_n, io_strobe_n, rw_dir, ctl_oe_n, bus_grant_ack_n, wait_complete_n;
  logic instr_fetch_n, machine_cycle_clock_out, misc_oe_n, mdl_ready;
  int error_cnt = 0, checked = 0, lat, mc, i, k;
  wire ready = loop ? wait_complete_n : mdl_ready;
  xbi_bus u_xbi_bus (.*);
  xbi_mem_model u_xbi_mem_model (.*, .ready(mdl_ready));
  initial forever #4 clk = ~clk;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic end_of_test;
    if (error_cnt == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // One whole access; lat counts edges from request to done
  task automatic acc(input logic [1:0] sp, input logic wr, input logic [2:0] a, input logic [2:0] n);
    rnd = lfsr(rnd);
    req_space = sp;
    req_write = wr;
    req_fetch = (sp == 2'h1);
    req_addr = {13'h0000, a};
    req_wdata = rnd;
    sw_wait_count = n;
    req_valid = 1'b1;
    lat = 0;
    mc = 0;
    for (k = 0; k < 40 && req_done !== 1'b1; k++) begin
      @(posedge clk);
      #1;
      lat++;
      mc += (wait_complete_n === 1'b0);
      if (memory_strobe_n === 1'b0 || io_strobe_n === 1'b0)
        `CHK({data_space_select_n, program_space_select_n, io_space_select_n, io_strobe_n, rw_dir, instr_fetch_n},
             {sp != 2'h0, sp != 2'h1, sp != 2'h2, sp != 2'h2, !wr, sp != 2'h1})
    end
    if (req_done !== 1'b1) begin
      error_cnt++;
      end_of_test();
    end
    req_valid = 1'b0;
    @(posedge clk);
    #1;
    `CHK(mc, (n >= 3'h2) ? n - 1 : 0)
    `CHK({data_oe_n, memory_strobe_n, io_strobe_n}, 3'h7)
    `CHK(addr_o, {13'h0000, a})
    if (wr) exp_mem[a] = rnd;
    if (wr) `CHK(data_o, rnd)
    else `CHK(req_rdata, exp_mem[a])
  endtask
  initial begin
    repeat (4) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (3) @(posedge clk);
    #1 `CHK({data_space_select_n, memory_strobe_n, rw_dir, data_oe_n, bus_grant_ack_n}, 5'h1F)
    for (i = 0; i < 8; i++) begin
      acc(i[0] ? 2'h2 : 2'h0, 1'b1, i[2:0], i[2:0]);
      `CHK(lat, i + 2)
    end
    for (i = 0; i < 8; i++) begin
      acc(i[0] ? 2'h1 : 2'h2, 1'b0, i[2:0], 3'h7 - i[2:0]);
      `CHK(lat, 9 - i)
    end
    slow = 3'h3;
    acc(2'h0, 1'b0, 3'h1, 3'h1);
    `CHK(lat, 3)
    acc(2'h0, 1'b0, 3'h2, 3'h2);
    `CHK(lat > 4, 1'b1)
    slow = 3'h0;
    loop = 1'b1;
    acc(2'h1, 1'b0, 3'h3, 3'h3);
    `CHK(lat, 6)
    loop = 1'b0;
    hold_req_n = 1'b0;
    for (k = 0; k < 20 && bus_grant_ack_n !== 1'b0; k++) @(posedge clk);
    #1 `CHK({bus_grant_ack_n, ctl_oe_n, addr_oe_n, data_oe_n}, 4'h7)
    hold_req_n = 1'b1;
    repeat (3) @(posedge clk);
    #1 output_disable_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 `CHK({ctl_oe_n, misc_oe_n, addr_oe_n, data_oe_n}, 4'hF)
    output_disable_n = 1'b1;
    device_reset_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 `CHK(data_oe_n, 1'b1)
    end_of_test();
  end
endmodule
`default_nettype wire

// *** test/xbi_mem_model.sv ***
/*
  External memory and I/O device model with a programmable ready delay.
  Assumes strobes and direction come straight from the bus pins.
*/
`timescale 1ns/100ps
`default_nettype none
module xbi_mem_model (
  // Bus pins
  input  wire logic        clk,
  input  wire logic        memory_strobe_n,
  input  wire logic        io_strobe_n,
  input  wire logic        rw_dir,
  input  wire logic [15:0] addr_o,
  input  wire logic [15:0] data_o,
  // Response
  input  wire logic [2:0]  slow,
  output logic [15:0]      data_i,
  output logic             ready
);
  logic [15:0] mem [0:255];
  logic [15:0] last = 16'h0000;
  logic [2:0]  cnt = 3'h0;
  wire         act = !memory_strobe_n || !io_strobe_n;
  // Ready stays low for the first slow cycles of an access
  assign ready = (cnt >= slow);
  // Released data lines show the inverse of the last value
  assign data_i = (act && rw_dir) ? mem[addr_o[7:0]] : ~last;
  always @(posedge clk) begin
    cnt <= act ? cnt + {2'h0, cnt != 3'h7} : 3'h0;
    if (act && rw_dir) last <= mem[addr_o[7:0]];
    if (act && !rw_dir) mem[addr_o[7:0]] <= data_o;
  end
endmodule
`default_nettype wire
